// ===== hw/dsmsel_defs.svh
// Behaviour
// - source codes 0000 software bit, 0001 pin, 0010-0101 pwm channels one to four
// - source codes 0110/0111 comparators, 1000/1001 sync serial, 1010 async transmit
// - source codes 1011 to 1111 connect nothing to the modulator
// - source register bit 7 blocks the selected source peripheral's own pin drive
// - high carrier register bit 7 blocks the selected carrier peripheral's pin drive
// - high carrier register bit 6 inverts the selected high carrier
// - with sync bit 5 set, switch to low waits for a high carrier falling edge
// - with sync clear, leave the high carrier as soon as the modulator drops
// - carrier codes 0000 low, 0001 pin one, 0010 pin two, 0011 reference clock
// - carrier codes 0100 to 0111 pick pwm channels one to four
// - carrier codes 1000 to 1111 connect no carrier
// - unsynchronised switching may leave narrowed carrier pulses in the stream
// - selection fields power up unknown and keep contents across other resets
// - output high carrier while modulator is one, low carrier while zero
// - disabled module forces the high carrier low and modulator to software bit, fields kept
// - synchronised switch lets the running carrier pulse end low first
`ifndef DSMSEL_DEFS_SVH
`define DSMSEL_DEFS_SVH

// register addresses
`define DSMSEL_MSRC_ADDR    4'h0
`define DSMSEL_HCAR_ADDR    4'h1
`define DSMSEL_MCON_ADDR    4'h2

// field positions
`define DSMSEL_ODIS_BIT     7
`define DSMSEL_INV_BIT      6
`define DSMSEL_SYNC_BIT     5
`define DSMSEL_SEL_MSB      3
`define DSMSEL_SEL_LSB      0
`define DSMSEL_EN_BIT       7
`define DSMSEL_OUT_BIT      3
`define DSMSEL_HSEL_BIT     1
`define DSMSEL_SWBIT_BIT    0

// writable masks and reset values
`define DSMSEL_MSRC_WMASK   8'h8F
`define DSMSEL_HCAR_WMASK   8'hEF
`define DSMSEL_MCON_WMASK   8'h81
`define DSMSEL_MCON_RST     8'h00
`define DSMSEL_RDATA_RST    8'h00

// modulation source codes
`define DSMSEL_MS_SOFT      4'h0
`define DSMSEL_MS_PIN       4'h1
`define DSMSEL_MS_PWM1      4'h2
`define DSMSEL_MS_PWM2      4'h3
`define DSMSEL_MS_PWM3      4'h4
`define DSMSEL_MS_PWM4      4'h5
`define DSMSEL_MS_CMP1      4'h6
`define DSMSEL_MS_CMP2      4'h7
`define DSMSEL_MS_SSP1      4'h8
`define DSMSEL_MS_SSP2      4'h9
`define DSMSEL_MS_ATX       4'hA

// high carrier codes
`define DSMSEL_HC_LOW       4'h0
`define DSMSEL_HC_CIN1      4'h1
`define DSMSEL_HC_CIN2      4'h2
`define DSMSEL_HC_REF       4'h3
`define DSMSEL_HC_PWM1      4'h4
`define DSMSEL_HC_PWM2      4'h5
`define DSMSEL_HC_PWM3      4'h6
`define DSMSEL_HC_PWM4      4'h7

`endif

// ===== hw/dsmsel_pkg.sv
package dsmsel_pkg;

  // on-chip peripheral outputs, all on the system clock
  typedef struct packed {
    logic [3:0] pwm;
    logic [1:0] cmp;
    logic       ssp1;
    logic       ssp2;
    logic       atx;
    logic       refclk;
  } dsmsel_periph_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dsmsel_bus_req_t;

  // carrier routing state
  typedef enum logic [1:0] {
    DSMSEL_SEL_LOW  = 2'b00,
    DSMSEL_SEL_HIGH = 2'b01,
    DSMSEL_WAIT_FALL = 2'b10
  } dsmsel_state_t;

endpackage

// ===== hw/dsmsel_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dsmsel_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// ===== hw/dsmsel_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsmsel_defs.svh"

module dsmsel_top (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    clk_en,
  input  wire dsmsel_pkg::dsmsel_bus_req_t bus_req,
  output var  logic [7:0]              bus_rdata,
  input  wire dsmsel_pkg::dsmsel_periph_t  periph,
  input  wire logic                    external_modulator_input_pin,
  input  wire logic                    carrier_input_pin_one,
  input  wire logic                    carrier_input_pin_two,
  input  wire logic                    carrier_low_in,
  output var  logic                    modulator_bit,
  output var  logic                    carrier_high,
  output var  logic                    modulated_carrier,
  output var  dsmsel_pkg::dsmsel_periph_t  pin_disable
);
  import dsmsel_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [2:0]      pins_s;
  logic            mod_pin_s;
  logic            cin1_s;
  logic            cin2_s;

  logic [7:0]      msrc_ff;
  logic [7:0]      hcar_ff;
  logic [7:0]      mcon_ff;
  logic [7:0]      rdata_ff;

  logic            enable;
  logic            soft_bit;
  logic            hc_invert;
  logic            hc_sync;
  logic [3:0]      eff_ms;
  logic [3:0]      eff_hc;

  logic            mod_ff;
  logic            hc_ff;
  logic            hc_prev_ff;
  logic            hc_fall;
  logic            out_ff;
  dsmsel_periph_t  pin_dis_ff;
  dsmsel_periph_t  nxt_pin_dis;

  dsmsel_state_t   state_ff;
  dsmsel_state_t   nxt_state;

  logic            wr_msrc;
  logic            wr_hcar;
  logic            wr_mcon;
  logic [7:0]      nxt_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // modulator source decode; reserved codes give a defined low
  function automatic logic mod_pick(
    input logic [3:0]     code,
    input logic           sw,
    input logic           pin,
    input dsmsel_periph_t p
  );
    logic r;
    r = 1'b0;
    unique case (code)
      `DSMSEL_MS_SOFT: r = sw;
      `DSMSEL_MS_PIN:  r = pin;
      `DSMSEL_MS_PWM1: r = p.pwm[0];
      `DSMSEL_MS_PWM2: r = p.pwm[1];
      `DSMSEL_MS_PWM3: r = p.pwm[2];
      `DSMSEL_MS_PWM4: r = p.pwm[3];
      `DSMSEL_MS_CMP1: r = p.cmp[0];
      `DSMSEL_MS_CMP2: r = p.cmp[1];
      `DSMSEL_MS_SSP1: r = p.ssp1;
      `DSMSEL_MS_SSP2: r = p.ssp2;
      `DSMSEL_MS_ATX:  r = p.atx;
      default:         r = 1'b0;
    endcase
    return r;
  endfunction

  // high carrier decode; code zero and reserved codes are both low
  function automatic logic car_pick(
    input logic [3:0]     code,
    input logic           c1,
    input logic           c2,
    input dsmsel_periph_t p
  );
    logic r;
    r = 1'b0;
    unique case (code)
      `DSMSEL_HC_LOW:  r = 1'b0;
      `DSMSEL_HC_CIN1: r = c1;
      `DSMSEL_HC_CIN2: r = c2;
      `DSMSEL_HC_REF:  r = p.refclk;
      `DSMSEL_HC_PWM1: r = p.pwm[0];
      `DSMSEL_HC_PWM2: r = p.pwm[1];
      `DSMSEL_HC_PWM3: r = p.pwm[2];
      `DSMSEL_HC_PWM4: r = p.pwm[3];
      default:         r = 1'b0;
    endcase
    return r;
  endfunction

  // peripheral whose own pin a source code points at; pins and constants have none
  function automatic dsmsel_periph_t ms_owner(input logic [3:0] code);
    dsmsel_periph_t m;
    m = '0;
    unique case (code)
      `DSMSEL_MS_PWM1: m.pwm[0] = 1'b1;
      `DSMSEL_MS_PWM2: m.pwm[1] = 1'b1;
      `DSMSEL_MS_PWM3: m.pwm[2] = 1'b1;
      `DSMSEL_MS_PWM4: m.pwm[3] = 1'b1;
      `DSMSEL_MS_CMP1: m.cmp[0] = 1'b1;
      `DSMSEL_MS_CMP2: m.cmp[1] = 1'b1;
      `DSMSEL_MS_SSP1: m.ssp1   = 1'b1;
      `DSMSEL_MS_SSP2: m.ssp2   = 1'b1;
      `DSMSEL_MS_ATX:  m.atx    = 1'b1;
      default:         m = '0;
    endcase
    return m;
  endfunction

  function automatic dsmsel_periph_t hc_owner(input logic [3:0] code);
    dsmsel_periph_t m;
    m = '0;
    unique case (code)
      `DSMSEL_HC_REF:  m.refclk = 1'b1;
      `DSMSEL_HC_PWM1: m.pwm[0] = 1'b1;
      `DSMSEL_HC_PWM2: m.pwm[1] = 1'b1;
      `DSMSEL_HC_PWM3: m.pwm[2] = 1'b1;
      `DSMSEL_HC_PWM4: m.pwm[3] = 1'b1;
      default:         m = '0;
    endcase
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  // pins are asynchronous; the edge detector below must never see a metastable level
  dsmsel_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .clk_en   (clk_en),
    .async_in ({external_modulator_input_pin, carrier_input_pin_one, carrier_input_pin_two}),
    .sync_out (pins_s)
  );

  assign mod_pin_s = pins_s[2];
  assign cin1_s    = pins_s[1];
  assign cin2_s    = pins_s[0];

  //////////////////////////////////////////////////////////////////////////////
  // register port

  assign wr_msrc = bus_req.wr && (bus_req.addr == `DSMSEL_MSRC_ADDR);
  assign wr_hcar = bus_req.wr && (bus_req.addr == `DSMSEL_HCAR_ADDR);
  assign wr_mcon = bus_req.wr && (bus_req.addr == `DSMSEL_MCON_ADDR);

  // selection fields carry no reset so that they survive rstn; they are
  // unknown until first written, which is harmless while the enable is low
  always_ff @(posedge clock) begin
    if (clk_en && wr_msrc) begin
      msrc_ff <= bus_req.wdata & `DSMSEL_MSRC_WMASK;
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && wr_hcar) begin
      hcar_ff <= bus_req.wdata & `DSMSEL_HCAR_WMASK;
    end
  end

  // control: enable and software bit, cleared by reset so the block starts idle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mcon_ff <= `DSMSEL_MCON_RST;
    end else if (clk_en && wr_mcon) begin
      mcon_ff <= bus_req.wdata & `DSMSEL_MCON_WMASK;
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    nxt_rdata = `DSMSEL_RDATA_RST;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `DSMSEL_MSRC_ADDR: nxt_rdata = msrc_ff;
        `DSMSEL_HCAR_ADDR: nxt_rdata = hcar_ff;
        `DSMSEL_MCON_ADDR: begin
          nxt_rdata = mcon_ff;
          nxt_rdata[`DSMSEL_OUT_BIT]  = out_ff;
          nxt_rdata[`DSMSEL_HSEL_BIT] = (state_ff != DSMSEL_SEL_LOW);
        end
        default: nxt_rdata = `DSMSEL_RDATA_RST;
      endcase
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= `DSMSEL_RDATA_RST;
    end else if (clk_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // effective selection

  assign enable    = mcon_ff[`DSMSEL_EN_BIT];
  assign soft_bit  = mcon_ff[`DSMSEL_SWBIT_BIT];
  assign hc_invert = hcar_ff[`DSMSEL_INV_BIT];
  assign hc_sync   = enable && hcar_ff[`DSMSEL_SYNC_BIT];

  // disabled: stored fields stay, but the paths act as software bit and low
  assign eff_ms = enable ? msrc_ff[`DSMSEL_SEL_MSB:`DSMSEL_SEL_LSB] : `DSMSEL_MS_SOFT;
  assign eff_hc = enable ? hcar_ff[`DSMSEL_SEL_MSB:`DSMSEL_SEL_LSB] : `DSMSEL_HC_LOW;

  //////////////////////////////////////////////////////////////////////////////
  // modulator and high carrier capture

  // one register stage each; the modulator and carrier stay aligned in time
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mod_ff <= 1'b0;
    end else if (clk_en) begin
      mod_ff <= mod_pick(eff_ms, soft_bit, mod_pin_s, periph);
    end
  end

  // inversion only while enabled, so a disabled block shows a quiet carrier
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hc_ff      <= 1'b0;
      hc_prev_ff <= 1'b0;
    end else if (clk_en) begin
      hc_ff      <= enable & (car_pick(eff_hc, cin1_s, cin2_s, periph) ^ hc_invert);
      hc_prev_ff <= hc_ff;
    end
  end

  // falling edge of the conditioned carrier, polarity already applied
  assign hc_fall = hc_prev_ff & ~hc_ff;

  //////////////////////////////////////////////////////////////////////////////
  // carrier switching

  // leaving high without sync may cut a pulse short; that is accepted behaviour
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DSMSEL_SEL_LOW: begin
        if (mod_ff) begin
          nxt_state = DSMSEL_SEL_HIGH;
        end
      end
      DSMSEL_SEL_HIGH: begin
        if (!mod_ff) begin
          if (!hc_sync || hc_fall) begin
            nxt_state = DSMSEL_SEL_LOW;
          end else begin
            nxt_state = DSMSEL_WAIT_FALL;
          end
        end
      end
      DSMSEL_WAIT_FALL: begin
        if (mod_ff) begin
          nxt_state = DSMSEL_SEL_HIGH;
        end else if (hc_fall || !hc_sync) begin
          nxt_state = DSMSEL_SEL_LOW;
        end
      end
      default: nxt_state = DSMSEL_SEL_LOW;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= DSMSEL_SEL_LOW;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // mixer: the waiting state still carries the high pulse until it ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_ff <= 1'b0;
    end else if (clk_en) begin
      out_ff <= (state_ff != DSMSEL_SEL_LOW) ? hc_ff : carrier_low_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // peripheral pin override

  // a peripheral is cut from its pin only while actually selected and enabled
  always_comb begin
    nxt_pin_dis = '0;
    if (enable && msrc_ff[`DSMSEL_ODIS_BIT]) begin
      nxt_pin_dis = nxt_pin_dis | ms_owner(eff_ms);
    end
    if (enable && hcar_ff[`DSMSEL_ODIS_BIT]) begin
      nxt_pin_dis = nxt_pin_dis | hc_owner(eff_hc);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_dis_ff <= '0;
    end else if (clk_en) begin
      pin_dis_ff <= nxt_pin_dis;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata         = rdata_ff;
  assign modulator_bit     = mod_ff;
  assign carrier_high      = hc_ff;
  assign modulated_carrier = out_ff;
  assign pin_disable       = pin_dis_ff;

endmodule

`default_nettype wire

// ===== testbench/dsmsel_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module dsmsel_periph_model (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 run,
  input  wire logic [13:0]          lvl,
  output var  dsmsel_pkg::dsmsel_periph_t periph,
  output var  logic                 mod_pin,
  output var  logic                 cin1,
  output var  logic                 cin2,
  output var  logic                 low_in
);
  import dsmsel_pkg::*;

  logic [3:0] cnt_ff;

  // free running divider standing in for the reference clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  // static levels unless the clock runs; slow clock so a cut pulse shows
  always_comb begin
    periph = lvl[9:0];
    if (run) begin
      periph.refclk = cnt_ff[3];
    end
  end
  assign mod_pin = lvl[10];
  assign cin1    = lvl[11];
  assign cin2    = lvl[12];
  assign low_in  = lvl[13];
endmodule

`default_nettype wire

// ===== testbench/dsmsel_properties.sv
`timescale 1ns/1ps
`default_nettype none

module dsmsel_checker (
  input wire logic                    clock,
  input wire logic                    rstn,
  input wire logic                    clk_en,
  input wire dsmsel_pkg::dsmsel_bus_req_t bus_req,
  input wire logic [7:0]              bus_rdata,
  input wire logic                    carrier_low_in,
  input wire logic                    modulator_bit,
  input wire logic                    carrier_high,
  input wire logic                    modulated_carrier,
  input wire dsmsel_pkg::dsmsel_periph_t  pin_disable
);
  import dsmsel_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // shadow of the carrier sync bit; with sync on and no falling edge the high
  // path may be held for good, so the low-carrier check only runs with sync off
  logic hc_sync_seen_ff;
  always_ff @(posedge clock) begin
    if (clk_en && bus_req.wr && bus_req.addr == 4'h1) begin
      hc_sync_seen_ff <= bus_req.wdata[5];
    end
  end

  // runs long enough that the carrier state has caught up; frozen cycles excluded
  sequence mod_hi_run;
    (clk_en && modulator_bit)[*3];
  endsequence
  sequence quiet_lo_run;
    (clk_en && !hc_sync_seen_ff && !modulator_bit && !carrier_high)[*4];
  endsequence

  ////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (
    $past(clk_en) && !$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_src_unused: assert property (
    $past(bus_req.rd && bus_req.addr == 4'h0) |-> bus_rdata[6:4] == 3'h0)
    else $error("source register unused bits not zero");
  chk_hcar_unused: assert property (
    $past(bus_req.rd && bus_req.addr == 4'h1) |-> bus_rdata[4] == 1'b0)
    else $error("carrier register unused bit not zero");
  chk_ctrl_unused: assert property (
    $past(bus_req.rd && bus_req.addr == 4'h2) |-> bus_rdata[6:4] == 3'h0 && !bus_rdata[2])
    else $error("control register unused bits not zero");
  chk_unmapped_zero: assert property (
    $past(bus_req.rd && bus_req.addr > 4'h2) |-> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  // mixer output follows the routed carrier one cycle late
  chk_mix_high: assert property (
    mod_hi_run |=> modulated_carrier == $past(carrier_high))
    else $error("output not following high carrier");
  chk_mix_low: assert property (
    quiet_lo_run |=> modulated_carrier == $past(carrier_low_in))
    else $error("output not following low carrier");
  chk_rise_cause: assert property (
    $rose(modulated_carrier) |-> $past(carrier_high) || $past(carrier_low_in))
    else $error("output rose with both carriers low");
  chk_reset_quiet: assert property (
    $rose(rstn) |-> !modulator_bit && !carrier_high && pin_disable == 10'h000)
    else $error("outputs active right after reset");
endmodule

bind dsmsel_top dsmsel_checker chk_u (.clock, .rstn, .clk_en, .bus_req, .bus_rdata,
  .carrier_low_in, .modulator_bit, .carrier_high, .modulated_carrier, .pin_disable);

`default_nettype wire

// ===== testbench/test_modulator_source_carrier_select.sv
`timescale 1ns/1ps
`default_nettype none

module test_modulator_source_carrier_select;
  import dsmsel_pkg::*;
  logic            clock, rstn, clk_en, run, mod_pin, cin1, cin2, low_in;
  logic            modulator_bit, carrier_high, modulated_carrier;
  logic [13:0]     lvl;
  logic [7:0]      bus_rdata;
  logic [9:0]      g;
  dsmsel_bus_req_t bus_req;
  dsmsel_periph_t  periph, pin_disable;
  int              n_fail, tests_run, i, n;
  // level index per code: 14 software bit, -2 constant low, -1 nothing
  int src_map[16] = '{14, 10, 6, 7, 8, 9, 4, 5, 3, 2, 1, -1, -1, -1, -1, -1};
  int car_map[16] = '{-2, 11, 12, 0, 6, 7, 8, 9, -1, -1, -1, -1, -1, -1, -1, -1};

  dsmsel_periph_model far_u (.clock, .rstn, .run, .lvl, .periph, .mod_pin, .cin1, .cin2,
    .low_in);
  dsmsel_top dut_u (.clock, .rstn, .clk_en, .bus_req, .bus_rdata, .periph,
    .external_modulator_input_pin(mod_pin), .carrier_input_pin_one(cin1),
    .carrier_input_pin_two(cin2), .carrier_low_in(low_in), .modulator_bit,
    .carrier_high, .modulated_carrier, .pin_disable);

  ////////////////////////////////////////////////////////////
  function automatic logic [13:0] hot(input int k);
    hot = (k >= 0 && k < 14) ? 14'h1 << k : 14'h0;
  endfunction
  function automatic logic [9:0] dis(input int k);
    dis = (k >= 0 && k < 10) ? 10'h1 << k : 10'h000;
  endfunction
  task automatic chk_bit(input string s, input logic e, input logic v);
    tests_run++;
    if (v !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %b got %b", s, e, v);
    end
  endtask
  task automatic chk_val(input string s, input logic [9:0] e, input logic [9:0] v);
    tests_run++;
    if (v !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, v);
    end
  endtask
  // strobe dropped a full cycle later so no signal is driven twice per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [9:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    @(posedge clock);
    d = 10'(bus_rdata);
  endtask
  task automatic settle();
    repeat (6) @(posedge clock);
  endtask
  // length of the carrier pulse under which the modulator drops
  task automatic cut_run(input logic [7:0] hc, output int len);
    wr(4'h1, hc);
    wr(4'h2, 8'h81);
    repeat (20) @(posedge clock);
    while (modulated_carrier === 1'b1) @(posedge clock);
    while (modulated_carrier !== 1'b1) @(posedge clock);
    bus_req <= '{addr: 4'h2, wdata: 8'h80, wr: 1'b1, rd: 1'b0};
    len = 0;
    do begin
      @(posedge clock);
      bus_req.wr <= 1'b0;
      len++;
    end while (modulated_carrier === 1'b1 && len < 20);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    run = 1'b0;
    lvl = 14'h0;
    bus_req = '0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(4'h2, g);
    chk_val("ctrl_rst", 10'h000, g);
    wr(4'h0, 8'hff);
    rd(4'h0, g);
    chk_val("src_mask", 10'h08f, g);
    wr(4'h1, 8'hff);
    rd(4'h1, g);
    chk_val("hcar_mask", 10'h0ef, g);
    wr(4'h9, 8'hff);
    rd(4'h9, g);
    chk_val("unmapped", 10'h000, g);
    wr(4'h1, 8'h00);
    for (int c = 0; c < 16; c++) begin
      i = src_map[c];
      lvl <= (i < 0) ? 14'h3fff : hot(i);
      wr(4'h0, 8'h80 | 8'(c));
      wr(4'h2, (i < 0 || i == 14) ? 8'h81 : 8'h80);
      settle();
      chk_bit("mod_sel", i >= 0, modulator_bit);
      chk_val("src_dis", dis(i), pin_disable);
      lvl <= ~hot(i);
      wr(4'h0, 8'(c));
      wr(4'h2, (i == 14) ? 8'h80 : 8'h81);
      settle();
      chk_bit("mod_other", 1'b0, modulator_bit);
      chk_val("src_keep", 10'h000, pin_disable);
    end
    // the loop left a reserved source code; route the software bit (one) again
    wr(4'h0, 8'h00);
    for (int c = 0; c < 16; c++) begin
      i = car_map[c];
      lvl <= (i == -1) ? 14'h3fff : hot(i);
      wr(4'h1, 8'h80 | 8'(c));
      settle();
      chk_bit("car_sel", i >= 0, carrier_high);
      chk_bit("mix_hi", i >= 0, modulated_carrier);
      chk_val("car_dis", dis(i), pin_disable);
      if (i != -1) begin
        lvl <= ~hot(i);
        wr(4'h1, 8'h40 | 8'(c));
        settle();
        chk_bit("car_inv", 1'b1, carrier_high);
      end
    end
    wr(4'h1, 8'h00);
    lvl <= 14'h2000;
    wr(4'h2, 8'h80);
    settle();
    chk_bit("mix_lo", 1'b1, modulated_carrier);
    // clock enable low: inputs move and a write is offered, nothing may change
    clk_en <= 1'b0;
    lvl <= 14'h0;
    wr(4'h2, 8'h81);
    settle();
    chk_bit("frozen_out", 1'b1, modulated_carrier);
    clk_en <= 1'b1;
    settle();
    chk_bit("frozen_wr", 1'b0, modulator_bit);
    chk_bit("thaw_out", 1'b0, modulated_carrier);
    lvl <= 14'h3fff;
    wr(4'h0, 8'h82);
    wr(4'h1, 8'h83);
    wr(4'h2, 8'h00);
    settle();
    chk_bit("off_mod", 1'b0, modulator_bit);
    chk_bit("off_car", 1'b0, carrier_high);
    chk_val("off_dis", 10'h000, pin_disable);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(4'h0, g);
    chk_val("src_kept", 10'h082, g);
    rd(4'h1, g);
    chk_val("hcar_kept", 10'h083, g);
    wr(4'h0, 8'h00);
    lvl <= 14'h0;
    run <= 1'b1;
    cut_run(8'h23, n);
    chk_val("sync_len", 10'd8, 10'(n));
    cut_run(8'h03, n);
    chk_bit("cut_len", 1'b1, n < 8);
    print_verdict();
  end
endmodule

`default_nettype wire
